// >>> logic/serial_char_receiver_pkg.sv
package serial_char_receiver_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_ADDR     = 8'h00;
    localparam logic [7:0]  PATCH_LO_ADDR = 8'h04;
    localparam logic [7:0]  PATCH_HI_ADDR = 8'h08;
    localparam logic [7:0]  STATUS_ADDR   = 8'h0c;

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int          CODE_LSB      = 0;
    localparam int          MODE_BIT      = 2;
    localparam int          FREE_STOP_BIT = 3;
    localparam int          UNITS_LSB     = 4;
    localparam int          PATCH_INV_BIT = 4;

    localparam logic [1:0]  CODE_5        = 2'h0;
    localparam logic [1:0]  CODE_6        = 2'h1;
    localparam logic [1:0]  CODE_7        = 2'h2;
    localparam logic [1:0]  CODE_8        = 2'h3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0050;
    localparam logic [31:0] PATCH_LO_RESET = 32'h0302_0100;
    localparam logic [31:0] PATCH_HI_RESET = 32'h0706_0504;

    // ------------------------------------------------------------
    // shift register and counter
    // ------------------------------------------------------------
    localparam int          STAGES        = 9;
    localparam int          LEVELS        = 8;
    localparam int          START_STAGE   = 8;
    localparam logic [3:0]  SYNC_PRESET   = 4'he;
    localparam logic [3:0]  SS_PRESET     = 4'hf;
    localparam logic        SPACE         = 1'b0;
    localparam logic        LEVEL_IDLE    = 1'b0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint      CLOCK_HZ       = 10_000_000;
    localparam longint      PRESET_TIME_US = 100;
    localparam longint      SAMPLE_TIME_MS = 2;
    localparam int          PRESET_CYCLES  = int'((PRESET_TIME_US * CLOCK_HZ + 999_999) / 1_000_000);
    localparam int          SAMPLE_CYCLES  = int'((SAMPLE_TIME_MS * CLOCK_HZ + 999) / 1_000);

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

// >>> logic/serial_char_receiver.sv
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// Functional notes
// - active stages equal selected levels plus one
// - 6-level enters stage three; 5-level stage four
// - 7-level skips first stage
// - start-stop start stage feeds no storage
// - continuous shifting; storage loads on character complete
// - any storage bit to any level, either polarity
// - eighth level idle unless 8-level codes
// - counter spans first to last bit, then resets
// - fixed count, or free stop length when enabled
// - free stop: idle while marking, spacing resumes
// - synchronous start state: first clear, rest set
// - sync shift pulse clears first, start-stop sets it; 100 us preset sets rest
// - start-stop start state all set
// - counter advances on rising bit clock
// - count sequence 0111 1011 0011 1101 0101 1001
// - at unit count emit shift pulse, reset counter
// - shift pulse loads register into storage
// - delayed shift pulse 100 us later
// - 2 ms sample: true external, inverted punch
// - punch sample punches stored character
// - larger unit counts extend same sequence
// - 6-unit start-stop: start plus five bits
// - start-stop counts one more pulse
// - start-stop sample only with start bit placed
module serial_char_receiver #(
    parameter int SAMPLE_CYCLES = serial_char_receiver_pkg::SAMPLE_CYCLES
) (
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [7:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    input  wire logic        i_bit_clock,
    input  wire logic        i_serial_data,
    output logic [7:0]       o_level,
    output logic             o_char_shift,
    output logic             o_delayed_shift,
    output logic             o_ext_sample,
    output logic             o_punch_sample_n
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] patch_lo_q;
    logic [31:0] patch_hi_q;
    logic        aw_got_q;
    logic        w_got_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [31:0] status;

    wire aw_fire   = i_awvalid & o_awready;
    wire w_fire    = i_wvalid & o_wready;
    wire aw_have   = aw_got_q | aw_fire;
    wire w_have    = w_got_q | w_fire;
    wire do_write  = aw_have & w_have & ~bvalid_q;
    wire [7:0]  wa = aw_got_q ? awaddr_q : i_awaddr;
    wire [31:0] wd = w_got_q ? wdata_q : i_wdata;
    wire [3:0]  ws = w_got_q ? wstrb_q : i_wstrb;
    wire wr_ctrl   = do_write & (wa == serial_char_receiver_pkg::CTRL_ADDR);
    wire wr_lo     = do_write & (wa == serial_char_receiver_pkg::PATCH_LO_ADDR);
    wire wr_hi     = do_write & (wa == serial_char_receiver_pkg::PATCH_HI_ADDR);
    wire wr_stat   = do_write & (wa == serial_char_receiver_pkg::STATUS_ADDR);
    wire wr_ok     = wr_ctrl | wr_lo | wr_hi | wr_stat;
    wire [31:0] ctrl_new = merge(ctrl_q, wd, ws) & 32'h0000_00ff;
    wire ar_fire   = i_arvalid & o_arready;

    logic [31:0] rd_mux;
    logic        rd_ok;
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b1;
        if (i_araddr == serial_char_receiver_pkg::CTRL_ADDR) begin
            rd_mux = ctrl_q;
        end else if (i_araddr == serial_char_receiver_pkg::PATCH_LO_ADDR) begin
            rd_mux = patch_lo_q;
        end else if (i_araddr == serial_char_receiver_pkg::PATCH_HI_ADDR) begin
            rd_mux = patch_hi_q;
        end else if (i_araddr == serial_char_receiver_pkg::STATUS_ADDR) begin
            rd_mux = status;
        end else begin
            rd_ok  = 1'b0;
        end
    end

    assign o_awready = ~aw_got_q & ~bvalid_q;
    assign o_wready  = ~w_got_q & ~bvalid_q;
    assign o_bvalid  = bvalid_q;
    assign o_bresp   = bresp_q;
    assign o_arready = ~rvalid_q;
    assign o_rvalid  = rvalid_q;
    assign o_rdata   = rdata_q;
    assign o_rresp   = rresp_q;

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= serial_char_receiver_pkg::RESP_OKAY;
        end else begin
            if (aw_fire) begin
                awaddr_q <= i_awaddr;
            end
            if (w_fire) begin
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            if (do_write) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? serial_char_receiver_pkg::RESP_OKAY : serial_char_receiver_pkg::RESP_SLVERR;
            end else begin
                aw_got_q <= aw_have;
                w_got_q  <= w_have;
                if (bvalid_q & i_bready) begin
                    bvalid_q <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            ctrl_q     <= serial_char_receiver_pkg::CTRL_RESET;
            patch_lo_q <= serial_char_receiver_pkg::PATCH_LO_RESET;
            patch_hi_q <= serial_char_receiver_pkg::PATCH_HI_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= ctrl_new;
            end
            if (wr_lo) begin
                patch_lo_q <= merge(patch_lo_q, wd, ws) & 32'h1f1f_1f1f;
            end
            if (wr_hi) begin
                patch_hi_q <= merge(patch_hi_q, wd, ws) & 32'h1f1f_1f1f;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= serial_char_receiver_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_ok ? serial_char_receiver_pkg::RESP_OKAY : serial_char_receiver_pkg::RESP_SLVERR;
        end else if (rvalid_q & i_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    wire [1:0] code_level = ctrl_q[serial_char_receiver_pkg::CODE_LSB +: 2];
    wire       start_stop = ctrl_q[serial_char_receiver_pkg::MODE_BIT];
    wire       free_stop  = ctrl_q[serial_char_receiver_pkg::FREE_STOP_BIT];
    wire [3:0] units      = ctrl_q[serial_char_receiver_pkg::UNITS_LSB +: 4];
    wire [63:0] patch     = {patch_hi_q, patch_lo_q};
    // entry stage: 8-level 0, 7-level 1, 6-level 2, 5-level 3
    wire [1:0] entry      = 2'h3 - code_level;

    // ------------------------------------------------------------
    // bit clock edges
    // ------------------------------------------------------------
    logic bclk_q;
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            // idle bit clock is high: no false rise after reset
            bclk_q <= 1'b1;
        end else begin
            bclk_q <= i_bit_clock;
        end
    end
    wire bclk_rise = i_bit_clock & ~bclk_q;
    wire bclk_fall = ~i_bit_clock & bclk_q;

    // ------------------------------------------------------------
    // shift register
    // ------------------------------------------------------------
    logic [serial_char_receiver_pkg::STAGES-1:0] sr_q;
    // shifts regardless of character boundaries, at bit centre
    for (genvar g = 0; g < serial_char_receiver_pkg::STAGES; g++) begin : g_stage
        always_ff @(posedge i_clock) begin
            if (!i_rstn) begin
                sr_q[g] <= 1'b0;
            end else if (bclk_fall) begin
                if (g == int'(entry)) begin
                    sr_q[g] <= i_serial_data;
                end else if (g > int'(entry)) begin
                    sr_q[g] <= sr_q[(g > 0) ? g - 1 : 0];
                end else begin
                    sr_q[g] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // units counter
    // ------------------------------------------------------------
    logic [3:0]  cnt_q;
    logic        gate_q;
    logic [15:0] preset_q;
    logic        delayed_q;
    wire        preset_busy = (preset_q != 16'h0000);
    wire [3:0]  start_val   = start_stop ? serial_char_receiver_pkg::SS_PRESET
                                         : serial_char_receiver_pkg::SYNC_PRESET;
    // down count from start value: terminal lies units pulses on
    wire [3:0]  term_val    = start_val - units;
    wire [3:0]  cnt_next    = cnt_q - 4'h1;
    wire        count_pulse = bclk_rise & gate_q & ~preset_busy;
    wire        char_hit    = count_pulse & (cnt_next == term_val);
    wire        preset_end  = (preset_q == 16'h0001);
    // start element must hold a spacing start bit
    wire        start_ok    = ~start_stop | (sr_q[serial_char_receiver_pkg::START_STAGE] == serial_char_receiver_pkg::SPACE);

    // pulses arriving inside the preset window are not counted; fine while a unit outlasts it
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            cnt_q <= serial_char_receiver_pkg::SYNC_PRESET;
        end else if (char_hit) begin
            cnt_q <= {cnt_q[3:1], start_stop};
        end else if (wr_ctrl) begin
            // a mode change must not leave the other framing's start state
            cnt_q <= ctrl_new[serial_char_receiver_pkg::MODE_BIT] ? serial_char_receiver_pkg::SS_PRESET
                                                                  : serial_char_receiver_pkg::SYNC_PRESET;
        end else if (preset_busy) begin
            cnt_q <= {3'b111, cnt_q[0]};
        end else if (count_pulse) begin
            cnt_q <= cnt_next;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            preset_q  <= 16'h0000;
            delayed_q <= 1'b0;
        end else begin
            delayed_q <= preset_end;
            if (char_hit) begin
                preset_q <= 16'(serial_char_receiver_pkg::PRESET_CYCLES);
            end else if (preset_busy) begin
                preset_q <= preset_q - 16'h0001;
            end
        end
    end

    // free stop: counting halts after a character until spacing
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            gate_q <= 1'b1;
        end else if (~(start_stop & free_stop)) begin
            gate_q <= 1'b1;
        end else if (bclk_fall & ~gate_q & (i_serial_data == serial_char_receiver_pkg::SPACE)) begin
            gate_q <= 1'b1;
        end else if (delayed_q) begin
            gate_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // storage and sample pulse
    // ------------------------------------------------------------
    logic [serial_char_receiver_pkg::STAGES-1:0] store_q;
    logic        shift_q;
    logic [15:0] sample_q;
    logic        sample_out_q;
    wire         sample_busy = (sample_q != 16'h0000);

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            store_q <= '0;
            shift_q <= 1'b0;
        end else begin
            shift_q <= char_hit;
            if (char_hit) begin
                store_q[7:0] <= sr_q[7:0];
                if (!start_stop) begin
                    store_q[8] <= sr_q[8];
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            sample_q     <= 16'h0000;
            sample_out_q <= 1'b0;
        end else begin
            sample_out_q <= sample_busy;
            if (char_hit & start_ok) begin
                sample_q <= 16'(SAMPLE_CYCLES);
            end else if (sample_busy) begin
                sample_q <= sample_q - 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // patch field and outputs
    // ------------------------------------------------------------
    logic [7:0] level_q;
    for (genvar l = 0; l < serial_char_receiver_pkg::LEVELS; l++) begin : g_level
        wire [3:0] sel = patch[l*8 +: 4];
        wire       inv = patch[l*8 + serial_char_receiver_pkg::PATCH_INV_BIT];
        wire       bit_v = (sel < 4'(serial_char_receiver_pkg::STAGES)) ? store_q[sel] : 1'b0;
        wire       gated = (l == 7) && (code_level != serial_char_receiver_pkg::CODE_8);
        always_ff @(posedge i_clock) begin
            if (!i_rstn) begin
                level_q[l] <= serial_char_receiver_pkg::LEVEL_IDLE;
            end else if (gated) begin
                level_q[l] <= serial_char_receiver_pkg::LEVEL_IDLE;
            end else begin
                level_q[l] <= bit_v ^ inv;
            end
        end
    end

    assign status = {16'h0000, preset_busy, sample_busy, gate_q, cnt_q, store_q};

    assign o_level          = level_q;
    assign o_char_shift     = shift_q;
    assign o_delayed_shift  = delayed_q;
    assign o_ext_sample     = sample_out_q;
    assign o_punch_sample_n = ~sample_out_q;

endmodule

// >>> test/serial_char_receiver_asserts.sv
`timescale 1ns/1ps
module serial_char_receiver_asserts #(
    parameter int SAMPLE_CYCLES = 20
) (
    input wire logic        i_clock,
    input wire logic        i_rstn,
    input wire logic        i_awvalid,
    input wire logic        o_awready,
    input wire logic        i_wvalid,
    input wire logic        o_wready,
    input wire logic        o_bvalid,
    input wire logic [7:0]  i_araddr,
    input wire logic        i_arvalid,
    input wire logic        o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0]  o_rresp,
    input wire logic        o_rvalid,
    input wire logic [7:0]  o_level,
    input wire logic        o_char_shift,
    input wire logic        o_delayed_shift,
    input wire logic        o_ext_sample,
    input wire logic        o_punch_sample_n
);
    int gap_q;
    int run_q;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    // --------------------------------
    // counters
    // --------------------------------
    // saturates so a long idle cannot wrap
    always_ff @(posedge i_clock) begin
        if (!i_rstn || o_char_shift) gap_q <= 0;
        else if (gap_q < 4000) gap_q <= gap_q + 1;
    end
    always_ff @(posedge i_clock) begin
        if (!i_rstn || !o_ext_sample) run_q <= 0;
        else run_q <= run_q + 1;
    end
    a_shift_single: assert property (o_char_shift |=> !o_char_shift)
        else $error("character shift longer than one cycle");
    a_punch_inverse: assert property (o_punch_sample_n == !o_ext_sample)
        else $error("punch sample not inverse of sample");
    a_sample_start: assert property ($rose(o_ext_sample) |-> $past(o_char_shift))
        else $error("sample started without character shift");
    a_sample_width: assert property ($fell(o_ext_sample) |-> run_q inside {[SAMPLE_CYCLES-1:SAMPLE_CYCLES+1]})
        else $error("sample pulse width wrong");
    a_delay_gap: assert property (o_delayed_shift |-> gap_q inside {[995:1005]})
        else $error("delayed shift at wrong distance");
    a_level_cause: assert property (!$stable(o_level) |-> $past(o_char_shift) || $past(o_bvalid))
        else $error("levels changed without load or write");
    a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |=> o_bvalid)
        else $error("no write response");
    a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid ##0 !o_arready)
        else $error("no read response");
    a_read_unmapped: assert property (i_arvalid && o_arready && i_araddr > 8'h0c
        |=> o_rresp == serial_char_receiver_pkg::RESP_SLVERR && o_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule

bind serial_char_receiver serial_char_receiver_asserts #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) asserts_i (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_araddr(i_araddr),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_rvalid(o_rvalid), .o_level(o_level), .o_char_shift(o_char_shift),
    .o_delayed_shift(o_delayed_shift), .o_ext_sample(o_ext_sample), .o_punch_sample_n(o_punch_sample_n)
);

// >>> test/line_sender.sv
`timescale 1ns/1ps
module line_sender #(
    parameter int HALF = 520
) (
    input  wire logic i_clock,
    input  wire logic i_run,
    output logic      o_bit_clock,
    output logic      o_data
);
    logic q[$];
    int   cnt_q = 0;
    logic first_q = 1'b1;
    initial begin
        o_bit_clock = 1'b1;
        o_data = 1'b1;
    end
    // --------------------------------
    // sender
    // --------------------------------
    // clock never pauses while running; an empty queue sends whole mark units
    always @(posedge i_clock) begin
        if (!i_run) begin
            o_bit_clock <= 1'b1;
            o_data <= 1'b1;
            cnt_q <= 0;
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
            cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
            if (cnt_q == HALF - 1) o_bit_clock <= ~o_bit_clock;
            // data moves with the rising clock, centre falls mid-bit
            if (first_q || (cnt_q == HALF - 1 && !o_bit_clock)) o_data <= (q.size() != 0) ? q.pop_front() : 1'b1;
        end
    end
endmodule

// >>> test/tb_serial_char_receiver.sv
`timescale 1ns/1ps
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin err_total++; $display("unexpected at %0t: %s", $time, m); end end
module tb_serial_char_receiver;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        run = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic        awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic [7:0]  araddr = 8'h00;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, bit_clock, sdata, char_shift, ext_sample;
    logic        prev_bc = 1'b1;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [7:0]  level;
    logic [1:0]  bq[$];
    logic [33:0] rq[$];
    logic [12:0] cq[$];
    int          err_total = 0;
    int          num_checks = 0;
    int          seed = 58460;
    int          rc = 0;
    int          rc_hold = 0;
    logic        shift_seen = 1'b0;

    serial_char_receiver #(.SAMPLE_CYCLES(20)) serial_char_receiver_i (
        .i_clock(clock), .i_rstn(rstn), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
        .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_bit_clock(bit_clock),
        .i_serial_data(sdata), .o_level(level), .o_char_shift(char_shift), .o_delayed_shift(),
        .o_ext_sample(ext_sample), .o_punch_sample_n()
    );
    line_sender #(.HALF(520)) line_sender_i (
        .i_clock(clock), .i_run(run), .o_bit_clock(bit_clock), .o_data(sdata)
    );

    initial forever #50 clock = ~clock;

    // --------------------------------
    // result monitor
    // --------------------------------
    always @(posedge clock) begin
        if (!run) rc <= 0;
        else if (bit_clock && !prev_bc) rc <= rc + 1;
        prev_bc <= bit_clock;
        if (char_shift) rc <= 0;
        if (rstn && bvalid && bready) `CHK(bresp, (bq.size() ? bq.pop_front() : 2'bxx), "write response")
        if (rstn && rvalid && rready) `CHK({rresp, rdata}, (rq.size() ? rq.pop_front() : 34'bx), "read data")
        // levels and sample pulse follow the shift pulse by one cycle
        shift_seen <= rstn && char_shift;
        if (char_shift) rc_hold <= rc;
        if (shift_seen) `CHK({rc_hold[3:0], ext_sample, level}, (cq.size() ? cq.pop_front() : 13'bx), "char")
    end

    task automatic summarize();
        if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic give_up();
        err_total++;
        $display("unexpected at %0t: no answer", $time);
        summarize();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 64);
        bready <= 1'b0;
        if (n >= 64) give_up();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        rq.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 64);
        rready <= 1'b0;
        if (n >= 64) give_up();
    endtask

    // expected levels: data through patch, unused levels at their invert bit, level eight gated below 8-level
    task automatic send_char(input int lv, input logic ss, input logic st, input int units, input logic [7:0] inv);
        logic [7:0] d;
        logic [7:0] e;
        d = 8'($random(seed));
        if (ss) line_sender_i.q.push_back(st);
        for (int i = 0; i < lv; i++) line_sender_i.q.push_back(d[i]);
        for (int n = 0; n < 8; n++) e[n] = (n < lv) ? d[n] ^ inv[n] : (n < 7) && inv[n];
        cq.push_back({units[3:0], !(ss && st), e});
    endtask

    task automatic run_case(input int lv, input logic ss, input logic fr, input int nc);
        logic [7:0]  inv;
        logic [31:0] p [2];
        int          units;
        int          k;
        int          n;
        rstn <= 1'b0;
        run <= 1'b0;
        line_sender_i.q.delete();
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        inv = 8'($random(seed));
        for (int b = 0; b < 8; b++) p[b/4][8*(b%4) +: 8] = {3'h0, inv[b], (b < lv) ? 4'(7 - b) : 4'h9};
        units = lv + ss;
        wr(serial_char_receiver_pkg::CTRL_ADDR, {24'h0, units[3:0], fr, ss, 2'(lv - 5)}, 2'h0);
        wr(serial_char_receiver_pkg::PATCH_LO_ADDR, p[0], 2'h0);
        wr(serial_char_receiver_pkg::PATCH_HI_ADDR, p[1], 2'h0);
        k = 0;
        for (int c = 0; c < nc; c++) begin
            send_char(lv, ss, ss && !fr && c == 1, units + k, inv);
            k = fr ? 1 + {$random(seed)} % 3 : 0;
            repeat (k) line_sender_i.q.push_back(1'b1);
        end
        run <= 1'b1;
        n = 0;
        while (cq.size() != 0 && n < 25000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 25000) give_up();
        repeat (1100) @(posedge clock);
    endtask

    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        rd(serial_char_receiver_pkg::CTRL_ADDR, serial_char_receiver_pkg::CTRL_RESET, 2'h0);
        rd(serial_char_receiver_pkg::PATCH_LO_ADDR, serial_char_receiver_pkg::PATCH_LO_RESET, 2'h0);
        rd(serial_char_receiver_pkg::PATCH_HI_ADDR, serial_char_receiver_pkg::PATCH_HI_RESET, 2'h0);
        rd(8'h10, 32'h0, serial_char_receiver_pkg::RESP_SLVERR);
        wr(8'h10, 32'hffff_ffff, serial_char_receiver_pkg::RESP_SLVERR);
        run_case(5, 1'b0, 1'b0, 2);
        run_case(6, 1'b0, 1'b0, 1);
        run_case(7, 1'b0, 1'b0, 1);
        run_case(8, 1'b0, 1'b0, 2);
        run_case(5, 1'b1, 1'b0, 2);
        run_case(5, 1'b1, 1'b1, 2);
        summarize();
    end
endmodule
